// ==== shared/arcf_pkg.sv ====
package arcf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ARCF_CTRL_OFS = 8'h02;
  localparam logic [7:0] ARCF_START_OFS = 8'h04;
  localparam logic [7:0] ARCF_CMPEN_OFS = 8'h08;
  localparam logic [7:0] ARCF_STAT_OFS = 8'h0A;
  localparam logic [7:0] ARCF_DIEN_OFS = 8'h0C;
  localparam logic [7:0] ARCF_CMPDIR_OFS = 8'h0E;
  localparam logic [7:0] ARCF_RES_OFS = 8'h10;
  localparam logic [7:0] ARCF_ISTAT_OFS = 8'h24;
  localparam logic [7:0] ARCF_ICLR_OFS = 8'h26;
  localparam logic [7:0] ARCF_IRQMASK_OFS = 8'h28;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ARCF_FASTCLR_BIT = 0;
  localparam int ARCF_JUSTIFY_BIT = 1;
  localparam int ARCF_RES_LSB = 2;
  localparam int ARCF_IRQEN_BIT = 4;
  localparam int ARCF_EV_DONE = 0;
  localparam int ARCF_EV_MATCH = 1;
  localparam logic [7:0] ARCF_BYTE_RST = 8'h00;
  localparam logic [15:0] ARCF_WORD_RST = 16'h0000;
  localparam logic [1:0] ARCF_IRQ_RST = 2'h0;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ARCF_RES8 = 2'h0,
    ARCF_RES10 = 2'h1,
    ARCF_RES12 = 2'h2
  } arcf_res_e;
  // one finished conversion from the converter core
  typedef struct packed {
    logic valid;
    logic [2:0] index;
    logic [11:0] data;
  } arcf_conv_s;
  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } arcf_bus_s;
endpackage

// ==== logic/arcf_result_map.sv ====
module arcf_result_map
  import arcf_pkg::*;
(
  input wire logic [11:0] raw, // converter code, right aligned
  input wire arcf_res_e res, // resolution
  input wire logic right_just, // 1 right justified
  output logic [15:0] word // register image
);
  // ---------------------------------------------------------------
  // mapping into 12-bit field, then into the 16-bit word
  // ---------------------------------------------------------------
  logic [11:0] field;

  // place code inside field by resolution and justification
  always_comb begin
    unique case (res)
      ARCF_RES8: field = right_just ? {4'h0, raw[7:0]} : {raw[7:0], 4'h0};
      ARCF_RES10: field = right_just ? {2'h0, raw[9:0]} : {raw[9:0], 2'h0};
      ARCF_RES12: field = raw;
      default: field = raw;
    endcase
  end

  // left justified field sits in the top bits, unused bits zero
  assign word = right_just ? {4'h0, field} : {field, 4'h0};
endmodule

// ==== logic/arcf_compare.sv ====
module arcf_compare
  import arcf_pkg::*;
(
  input wire logic [15:0] result_word, // mapped conversion result
  input wire logic [15:0] compare_word, // stored compare value
  input wire logic right_just, // justification of both words
  input wire logic higher, // direction select bit
  output logic hit // comparison holds
);
  // ---------------------------------------------------------------
  // full 12-bit compare
  // ---------------------------------------------------------------
  function automatic logic [11:0] arcf_field(input logic [15:0] w, input logic right);
    arcf_field = right ? w[11:0] : w[15:4];
  endfunction

  logic [11:0] res_f;
  logic [11:0] cmp_f;

  // both operands always carry twelve bits regardless of resolution
  assign res_f = arcf_field(result_word, right_just);
  assign cmp_f = arcf_field(compare_word, right_just);
  // 0: lower or same, 1: strictly higher
  assign hit = higher ? (res_f > cmp_f) : (res_f <= cmp_f);
endmodule

// ==== logic/arcf_top.sv ====
module arcf_top
  import arcf_pkg::*;
#(
  parameter int NCONV = 8 // result registers and flags
) (
  input wire logic core_clk, // block clock, 125 MHz
  input wire logic resetn, // asynchronous reset, low active
  input wire arcf_pkg::arcf_bus_s bus_in, // register bus request
  output logic [15:0] rdata, // read data, cycle after read strobe
  input wire arcf_pkg::arcf_conv_s conv_in, // finished conversion
  output logic seq_start, // pulse: new sequence requested
  output logic seq_abort, // pulse: running sequence aborted
  output logic [1:0] res_sel, // resolution to converter core
  output logic [NCONV-1:0] digital_buffer_enable, // pin input buffer enables
  output logic compare_irq_req, // pulse: compare interrupt request
  output logic irq // level interrupt
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [NCONV-1:0] conversion_done_flag;
  logic [NCONV-1:0] next_conversion_done_flag;
  logic [NCONV-1:0] compare_enable_reg;
  logic [NCONV-1:0] compare_direction_reg;
  logic [NCONV-1:0] digital_input_enable_reg;
  logic [4:0] result_format_control;
  logic [15:0] result_register [NCONV];
  logic [1:0] irq_status;
  logic [1:0] irq_enable;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic arcf_is_res(input logic [7:0] a);
    arcf_is_res = (a[7:4] == ARCF_RES_OFS[7:4]) && !a[0];
  endfunction

  logic fast_flag_clear;
  logic justify_select;
  logic compare_irq_enable;
  logic wr_stat;
  logic wr_start;
  logic wr_res;
  logic rd_res;
  logic [2:0] bus_idx;
  logic [2:0] cidx;
  logic [15:0] mapped;
  logic hit;
  logic conv_store;
  logic conv_set;
  logic match_ev;

  assign fast_flag_clear = result_format_control[ARCF_FASTCLR_BIT];
  assign justify_select = result_format_control[ARCF_JUSTIFY_BIT];
  assign compare_irq_enable = result_format_control[ARCF_IRQEN_BIT];
  assign bus_idx = bus_in.addr[3:1];
  assign cidx = conv_in.index;
  assign wr_stat = bus_in.wr && (bus_in.addr == ARCF_STAT_OFS);
  assign wr_start = bus_in.wr && (bus_in.addr == ARCF_START_OFS);
  assign wr_res = bus_in.wr && arcf_is_res(bus_in.addr);
  assign rd_res = bus_in.rd && arcf_is_res(bus_in.addr);

  // ---------------------------------------------------------------
  // result mapping and compare
  // ---------------------------------------------------------------
  arcf_result_map u_map (
    .raw(conv_in.data),
    .res(arcf_res_e'(result_format_control[ARCF_RES_LSB +: 2])),
    .right_just(justify_select),
    .word(mapped)
  );

  arcf_compare u_cmp (
    .result_word(mapped),
    .compare_word(result_register[cidx]),
    .right_just(justify_select),
    .higher(compare_direction_reg[cidx]),
    .hit(hit)
  );

  // stored only when compare is off; a hit sets the flag when compare is on
  assign conv_store = conv_in.valid && !compare_enable_reg[cidx];
  assign match_ev = conv_in.valid && compare_enable_reg[cidx] && hit;
  assign conv_set = conv_store || match_ev;

  // ---------------------------------------------------------------
  // completion flags
  // ---------------------------------------------------------------
  // per-bit set/clear with start clear first, then set, then soft clears
  always_comb begin
    for (int n = 0; n < NCONV; n++) begin
      if (wr_start) begin
        next_conversion_done_flag[n] = 1'b0;
      end else if (conv_set && (cidx == 3'(n))) begin
        next_conversion_done_flag[n] = 1'b1;
      end else if (wr_stat && !fast_flag_clear && bus_in.wdata[n]) begin
        next_conversion_done_flag[n] = 1'b0;
      end else if (rd_res && fast_flag_clear && !compare_enable_reg[n]
                   && (bus_idx == 3'(n))) begin
        next_conversion_done_flag[n] = 1'b0;
      end else if (wr_res && fast_flag_clear && compare_enable_reg[n]
                   && (bus_idx == 3'(n))) begin
        next_conversion_done_flag[n] = 1'b0;
      end else begin
        next_conversion_done_flag[n] = conversion_done_flag[n];
      end
    end
  end

  // flag register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      conversion_done_flag <= '0;
    end else begin
      conversion_done_flag <= next_conversion_done_flag;
    end
  end

  // ---------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------
  // converter store wins over a software write to the same slot
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int n = 0; n < NCONV; n++) begin
        result_register[n] <= ARCF_WORD_RST;
      end
    end else begin
      if (wr_res) begin
        result_register[bus_idx] <= bus_in.wdata &
          (justify_select ? 16'h0FFF : 16'hFFF0);
      end
      if (conv_store) begin
        result_register[cidx] <= mapped;
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // software written configuration
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      compare_enable_reg <= '0;
      compare_direction_reg <= '0;
      digital_input_enable_reg <= '0;
      result_format_control <= '0;
      irq_enable <= ARCF_IRQ_RST;
    end else if (bus_in.wr) begin
      unique case (bus_in.addr)
        ARCF_CMPEN_OFS: compare_enable_reg <= bus_in.wdata[NCONV-1:0];
        ARCF_CMPDIR_OFS: compare_direction_reg <= bus_in.wdata[NCONV-1:0];
        ARCF_DIEN_OFS: digital_input_enable_reg <= bus_in.wdata[NCONV-1:0];
        ARCF_CTRL_OFS: result_format_control <= bus_in.wdata[4:0];
        ARCF_IRQMASK_OFS: irq_enable <= bus_in.wdata[1:0];
        default: ;
      endcase
    end
  end

  // sequence control pulses to the converter core
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      seq_start <= 1'b0;
      seq_abort <= 1'b0;
    end else begin
      seq_start <= wr_start;
      seq_abort <= bus_in.wr && ((bus_in.addr == ARCF_CMPDIR_OFS) ||
                   (bus_in.addr == ARCF_CMPEN_OFS));
    end
  end

  // configuration mirrored to outputs from flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      digital_buffer_enable <= '0;
      res_sel <= 2'h0;
    end else begin
      digital_buffer_enable <= next_dien();
      res_sel <= next_res();
    end
  end

  function automatic logic [NCONV-1:0] next_dien();
    next_dien = (bus_in.wr && bus_in.addr == ARCF_DIEN_OFS) ?
      bus_in.wdata[NCONV-1:0] : digital_input_enable_reg;
  endfunction

  function automatic logic [1:0] next_res();
    next_res = (bus_in.wr && bus_in.addr == ARCF_CTRL_OFS) ?
      bus_in.wdata[ARCF_RES_LSB +: 2] : result_format_control[ARCF_RES_LSB +: 2];
  endfunction

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [1:0] ev;
  logic [1:0] next_irq_status;
  logic [1:0] clr;

  assign ev[ARCF_EV_DONE] = conv_set;
  assign ev[ARCF_EV_MATCH] = match_ev;
  assign clr = (bus_in.wr && bus_in.addr == ARCF_ICLR_OFS) ? bus_in.wdata[1:0] : 2'h0;
  // set beats a same-cycle clear
  assign next_irq_status = ev | (irq_status & ~clr);

  // sticky status, level output, compare request pulse
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= ARCF_IRQ_RST;
      irq <= 1'b0;
      compare_irq_req <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & next_irq_mask());
      compare_irq_req <= match_ev && compare_irq_enable;
    end
  end

  function automatic logic [1:0] next_irq_mask();
    next_irq_mask = (bus_in.wr && bus_in.addr == ARCF_IRQMASK_OFS) ?
      bus_in.wdata[1:0] : irq_enable;
  endfunction

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // read data stand in the cycle after the strobe only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= ARCF_WORD_RST;
    end else if (!bus_in.rd) begin
      rdata <= ARCF_WORD_RST;
    end else if (arcf_is_res(bus_in.addr)) begin
      rdata <= result_register[bus_idx];
    end else begin
      unique case (bus_in.addr)
        ARCF_STAT_OFS: rdata <= {8'h00, conversion_done_flag};
        ARCF_CMPEN_OFS: rdata <= {8'h00, compare_enable_reg};
        ARCF_CMPDIR_OFS: rdata <= {8'h00, compare_direction_reg};
        ARCF_DIEN_OFS: rdata <= {8'h00, digital_input_enable_reg};
        ARCF_CTRL_OFS: rdata <= {11'h000, result_format_control};
        ARCF_ISTAT_OFS: rdata <= {14'h0000, irq_status};
        ARCF_IRQMASK_OFS: rdata <= {14'h0000, irq_enable};
        default: rdata <= ARCF_WORD_RST;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_plain_conv;
    conv_in.valid && !compare_enable_reg[cidx] && !wr_start;
  endsequence

  sequence s_match_conv;
    match_ev && !wr_start;
  endsequence

  chk_flag_set: assert property (s_plain_conv |=> conversion_done_flag[$past(cidx)])
    else $error("flag not set after plain conversion");

  chk_store_res: assert property (
      s_plain_conv |=> result_register[$past(cidx)] == $past(mapped))
    else $error("result not stored");

  chk_match_set: assert property (s_match_conv |=> conversion_done_flag[$past(cidx)])
    else $error("flag not set after compare hit");

  chk_cmp_irq: assert property (match_ev && compare_irq_enable |=> compare_irq_req)
    else $error("compare irq not requested");

  chk_cmp_quiet: assert property (!match_ev |=> !compare_irq_req)
    else $error("compare irq without compare hit");

  chk_miss_clear: assert property (
      conv_in.valid && compare_enable_reg[cidx] && !hit && !conversion_done_flag[cidx]
      |=> !conversion_done_flag[$past(cidx)])
    else $error("flag set without compare hit");

  chk_cmp_hold: assert property (
      conv_in.valid && compare_enable_reg[cidx] && !wr_res
      |=> result_register[$past(cidx)] == $past(result_register[cidx]))
    else $error("compare value overwritten");

  chk_start_clr: assert property (wr_start |=> conversion_done_flag == '0 && seq_start)
    else $error("start did not clear flags");

  chk_w1c_flag: assert property (
      wr_stat && !fast_flag_clear && !conv_in.valid && !wr_start
      |=> (conversion_done_flag & $past(bus_in.wdata[NCONV-1:0])) == '0)
    else $error("write one did not clear flag");

  chk_w0_keep: assert property (
      wr_stat && !fast_flag_clear && !conv_in.valid
      |=> (conversion_done_flag & ~$past(bus_in.wdata[NCONV-1:0]))
          == ($past(conversion_done_flag) & ~$past(bus_in.wdata[NCONV-1:0])))
    else $error("write zero changed a flag");

  chk_stat_keep: assert property (
      wr_stat && fast_flag_clear && !conv_in.valid
      |=> conversion_done_flag == $past(conversion_done_flag))
    else $error("flag write with fast clear changed flags");

  chk_stat_read: assert property (
      bus_in.rd && bus_in.addr == ARCF_STAT_OFS
      |=> rdata[NCONV-1:0] == $past(conversion_done_flag))
    else $error("flag read returned wrong value");

  chk_flag_quiet: assert property (
      !conv_in.valid && !bus_in.wr && !bus_in.rd
      |=> $stable(conversion_done_flag))
    else $error("flags changed without an event");

  chk_fast_read: assert property (
      rd_res && fast_flag_clear && !compare_enable_reg[bus_idx] && !conv_in.valid
      |=> !conversion_done_flag[$past(bus_idx)])
    else $error("fast clear by read failed");

  chk_fast_write: assert property (
      wr_res && fast_flag_clear && compare_enable_reg[bus_idx] && !conv_in.valid
      |=> !conversion_done_flag[$past(bus_idx)])
    else $error("fast clear by write failed");

  chk_set_wins: assert property (
      conv_set && !wr_start && wr_stat
      |=> conversion_done_flag[$past(cidx)])
    else $error("set lost to soft clear");

  chk_abort_pulse: assert property (
      bus_in.wr && bus_in.addr == ARCF_CMPDIR_OFS
      |=> seq_abort)
    else $error("no abort after direction write");

  chk_compare_enable_bit_abort: assert property (
      bus_in.wr && bus_in.addr == ARCF_CMPEN_OFS
      |=> seq_abort)
    else $error("no abort after compare enable write");

  chk_buf_follow: assert property (
      bus_in.wr && bus_in.addr == ARCF_DIEN_OFS
      |=> digital_buffer_enable == $past(bus_in.wdata[NCONV-1:0]))
    else $error("buffer enable not following register");

  chk_buf_hold: assert property (
      !(bus_in.wr && bus_in.addr == ARCF_DIEN_OFS)
      |=> $stable(digital_buffer_enable))
    else $error("buffer enable changed without a write");

  chk_irq_level: assert property (irq == |(irq_status & irq_enable))
    else $error("irq level not matching enabled status");

  chk_rdata_idle: assert property (!bus_in.rd |=> rdata == '0)
    else $error("read data not zero outside a read");
endmodule

// ==== sim/arcf_top_test.sv ====
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module arcf_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import arcf_pkg::*;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk;
  logic resetn;
  arcf_bus_s bus_in;
  arcf_conv_s conv_in;
  logic [15:0] rdata;
  logic seq_start;
  logic seq_abort;
  logic [1:0] res_sel;
  logic [7:0] digital_buffer_enable;
  logic compare_irq_req;
  logic irq;
  int bad_count;
  int n_compared;
  logic [15:0] exp_q[$];
  logic [15:0] mon_exp;
  logic rd_seen;
  logic [7:0] offs[6] = '{ARCF_STAT_OFS, ARCF_DIEN_OFS, ARCF_CMPDIR_OFS, ARCF_CMPEN_OFS,
                          ARCF_RES_OFS + 8'h0E, 8'h30};

  arcf_top dut_u (
    .core_clk(core_clk),
    .resetn(resetn),
    .bus_in(bus_in),
    .rdata(rdata),
    .conv_in(conv_in),
    .seq_start(seq_start),
    .seq_abort(seq_abort),
    .res_sel(res_sel),
    .digital_buffer_enable(digital_buffer_enable),
    .compare_irq_req(compare_irq_req),
    .irq(irq)
  );

  // clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // expected result image
  // ---------------------------------------------------------------
  // 12-bit field of a raw code for a resolution and justification
  function automatic logic [11:0] fld(logic [11:0] raw, int res, logic rj);
    case (res)
      0: return rj ? {4'h0, raw[7:0]} : {raw[7:0], 4'h0};
      1: return rj ? {2'b00, raw[9:0]} : {raw[9:0], 2'b00};
      default: return raw;
    endcase
  endfunction

  // register word holding a 12-bit field
  function automatic logic [15:0] word(logic [11:0] f, logic rj);
    return rj ? {4'h0, f} : {f, 4'h0};
  endfunction

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  // one bus and converter cycle, released at the edge that samples it
  task automatic cyc(arcf_bus_s b, arcf_conv_s c);
    @(posedge core_clk);
    bus_in <= b;
    conv_in <= c;
    @(posedge core_clk);
    bus_in <= '0;
    conv_in <= '0;
  endtask

  task automatic wr(logic [7:0] a, logic [15:0] d);
    cyc('{1'b1, 1'b0, a, d}, '0);
  endtask

  // read with the expected word noted for the monitor
  task automatic rd(logic [7:0] a, logic [15:0] e);
    exp_q.push_back(e);
    cyc('{1'b0, 1'b1, a, 16'h0000}, '0);
  endtask

  task automatic conv(logic [2:0] i, logic [11:0] d);
    cyc('0, '{1'b1, i, d});
  endtask

  // ---------------------------------------------------------------
  // monitor: read data stand only in the cycle after the strobe
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    rd_seen <= bus_in.rd;
  end

  always @(negedge core_clk) begin
    if (rd_seen === 1'b1) begin
      mon_exp = exp_q.pop_front();
      `CHK(rdata, mon_exp);
    end
  end

  // ---------------------------------------------------------------
  // closing and watchdog
  // ---------------------------------------------------------------
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    bad_count++;
    results();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [2:0] idx;
    logic [11:0] raw;
    logic [11:0] cv;
    logic [11:0] rv;
    logic [7:0] dv;
    logic hit;
    void'($urandom(32'h7C8AED61));
    bus_in = '0;
    conv_in = '0;
    resetn = 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    // reset values and an unmapped place read zero
    foreach (offs[k]) rd(offs[k], 16'h0000);
    // every resolution and justification, compare off
    for (int r = 0; r < 3; r++) begin
      for (int j = 0; j < 2; j++) begin
        idx = 3'($urandom_range(7, 0));
        raw = 12'($urandom());
        wr(ARCF_CTRL_OFS, 16'(r * 4 + j * 2));
        #1 `CHK(res_sel, 2'(r));
        wr(ARCF_START_OFS, 16'h0000);
        #1 `CHK(seq_start, 1'b1);
        conv(idx, raw);
        rd(ARCF_RES_OFS + 8'(2 * idx), word(fld(raw, r, j[0]), j[0]));
        rd(ARCF_STAT_OFS, 16'(8'h01 << idx));
      end
    end
    // fast clear off: write one clears, zero keeps
    wr(ARCF_START_OFS, 16'h0000);
    conv(3'd2, 12'($urandom()));
    conv(3'd5, 12'($urandom()));
    wr(ARCF_STAT_OFS, 16'h0004);
    rd(ARCF_STAT_OFS, 16'h0020);
    wr(ARCF_STAT_OFS, 16'h0000);
    rd(ARCF_STAT_OFS, 16'h0020);
    // same-cycle set against soft clear and against start
    cyc('{1'b1, 1'b0, ARCF_STAT_OFS, 16'h0020}, '{1'b1, 3'd5, 12'h123});
    rd(ARCF_STAT_OFS, 16'h0020);
    cyc('{1'b1, 1'b0, ARCF_START_OFS, 16'h0000}, '{1'b1, 3'd1, 12'h456});
    rd(ARCF_STAT_OFS, 16'h0000);
    // fast clear on, compare off: result read clears
    wr(ARCF_CTRL_OFS, 16'h000B);
    raw = 12'($urandom());
    conv(3'd6, raw);
    wr(ARCF_STAT_OFS, 16'h00FF);
    rd(ARCF_STAT_OFS, 16'h0040);
    rd(ARCF_RES_OFS + 8'h0C, word(raw, 1'b1));
    rd(ARCF_STAT_OFS, 16'h0000);
    // digital input buffers follow their enable bits
    dv = 8'($urandom());
    wr(ARCF_DIEN_OFS, {8'h00, dv});
    #1 `CHK(digital_buffer_enable, dv);
    rd(ARCF_DIEN_OFS, {8'h00, dv});
    // compare on slot 7, both directions, boundaries around the value
    wr(ARCF_CMPEN_OFS, 16'h0080);
    #1 `CHK(seq_abort, 1'b1);
    wr(ARCF_IRQMASK_OFS, 16'h0002);
    cv = 12'($urandom_range(4094, 1));
    for (int h = 0; h < 2; h++) begin
      wr(ARCF_CTRL_OFS, 16'(16'h0019 | (h << 1)));
      for (int d = -1; d < 2; d++) begin
        rv = 12'(int'(cv) + d);
        hit = h ? (rv > cv) : (rv <= cv);
        wr(ARCF_CMPDIR_OFS, 16'(h << 7));
        #1 `CHK(seq_abort, 1'b1);
        wr(ARCF_RES_OFS + 8'h0E, word(cv, h[0]));
        wr(ARCF_ICLR_OFS, 16'h0003);
        wr(ARCF_START_OFS, 16'h0000);
        conv(3'd7, rv);
        #1 `CHK(compare_irq_req, hit);
        rd(ARCF_STAT_OFS, {8'h00, hit, 7'h00});
        rd(ARCF_RES_OFS + 8'h0E, word(cv, h[0]));
        rd(ARCF_ISTAT_OFS, {14'h0000, hit, hit});
        #1 `CHK(irq, hit);
        wr(ARCF_RES_OFS + 8'h0E, word(cv, h[0]));
        rd(ARCF_STAT_OFS, 16'h0000);
      end
    end
    // interrupt masked, unmasked, then cleared
    wr(ARCF_IRQMASK_OFS, 16'h0000);
    rd(ARCF_ISTAT_OFS, 16'h0003);
    #1 `CHK(irq, 1'b0);
    wr(ARCF_IRQMASK_OFS, 16'h0002);
    rd(ARCF_ISTAT_OFS, 16'h0003);
    #1 `CHK(irq, 1'b1);
    wr(ARCF_ICLR_OFS, 16'h0003);
    rd(ARCF_ISTAT_OFS, 16'h0000);
    #1 `CHK(irq, 1'b0);
    repeat (2) @(posedge core_clk);
    results();
  end
endmodule
